// [hw/dfp_pkg.sv]
// constants and types shared by the driver fault protection block
package dfp_pkg;

  // ==========================================================
  // clock and timing
  localparam int DFP_CLK_MHZ = 25;
  localparam int DFP_DELAY_00_NS = 3200;
  localparam int DFP_DELAY_01_NS = 1600;
  localparam int DFP_DELAY_10_NS = 1200;
  localparam int DFP_DELAY_11_NS = 800;
  localparam int DFP_RETRY_PAUSE_NS = 12800;
  localparam int DFP_RETRIES = 3;
  localparam int DFP_CNT_W = 9;

  // least times round up to whole cycles
  localparam int DFP_DELAY_00_CYC = (DFP_DELAY_00_NS * DFP_CLK_MHZ + 999) / 1000;
  localparam int DFP_DELAY_01_CYC = (DFP_DELAY_01_NS * DFP_CLK_MHZ + 999) / 1000;
  localparam int DFP_DELAY_10_CYC = (DFP_DELAY_10_NS * DFP_CLK_MHZ + 999) / 1000;
  localparam int DFP_DELAY_11_CYC = (DFP_DELAY_11_NS * DFP_CLK_MHZ + 999) / 1000;
  localparam int DFP_PAUSE_CYC = (DFP_RETRY_PAUSE_NS * DFP_CLK_MHZ + 999) / 1000;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] DFP_ADDR_CONFIG = 8'h00;
  localparam logic [7:0] DFP_ADDR_STATUS = 8'h04;

  // config register fields
  localparam int DFP_CFG_SENSITIVITY = 0;
  localparam int DFP_CFG_DELAY = 1;
  localparam int DFP_CFG_PROTECT_DIS = 3;
  localparam int DFP_CFG_LS_ENABLE = 4;
  localparam int DFP_CFG_THRESH_SEL = 5;
  localparam int DFP_CFG_LOW_SUPPLY = 6;
  localparam int DFP_CFG_SLOPE = 7;
  localparam int DFP_CFG_OFF_TIME = 9;
  localparam int DFP_CFG_SCALE = 13;
  localparam int DFP_CFG_W = 18;
  localparam logic [DFP_CFG_W-1:0] DFP_CFG_RESET = 18'h00000;

  // status register fields
  localparam int DFP_ST_SHORT = 0;
  localparam int DFP_ST_LS_SHORT = 2;
  localparam int DFP_ST_HS_SHORT = 4;
  localparam int DFP_ST_OPEN_LOAD = 6;
  localparam int DFP_ST_PREWARN = 8;
  localparam int DFP_ST_THERMAL = 9;
  localparam int DFP_ST_SCALE = 10;

  // ==========================================================
  // high-side slope modes
  localparam logic [1:0] DFP_SLOPE_MIN = 2'h0;
  localparam logic [1:0] DFP_SLOPE_MIN_TC = 2'h1;
  localparam logic [1:0] DFP_SLOPE_MED_TC = 2'h2;
  localparam logic [1:0] DFP_SLOPE_MAX = 2'h3;

  // per-coil short supervision states
  typedef enum logic [1:0] {
    DFP_ARMED = 2'b00,
    DFP_PAUSE = 2'b01,
    DFP_LOCKED = 2'b10
  } dfp_fsm_t;

  // detection delay in cycles from the two-bit field
  function automatic logic [DFP_CNT_W-1:0] dfp_delay_cycles(input logic [1:0] sel);
    logic [DFP_CNT_W-1:0] r;
    r = DFP_CNT_W'(DFP_DELAY_00_CYC);
    unique case (sel)
      2'h0: r = DFP_CNT_W'(DFP_DELAY_00_CYC);
      2'h1: r = DFP_CNT_W'(DFP_DELAY_01_CYC);
      2'h2: r = DFP_CNT_W'(DFP_DELAY_10_CYC);
      2'h3: r = DFP_CNT_W'(DFP_DELAY_11_CYC);
    endcase
    return r;
  endfunction

endpackage

// [hw/dfp_sync.sv]
// three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module dfp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins and filtered result
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } dfp_sync_t;

  dfp_sync_t r;
  dfp_sync_t next_r;

  // ==========================================================
  // next state
  always_comb begin
    next_r = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.q = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.q);
    if (rst) begin
      next_r.s1 = INIT;
      next_r.s2 = INIT;
      next_r.s3 = INIT;
      next_r.q = INIT;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  assign q = r.q;

endmodule

`default_nettype wire

// [hw/dfp_top.sv]
// fault supervision of a two-coil power stage with a wishbone register file
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module dfp_top
  import dfp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // asynchronous pins and comparators
  input wire logic driver_disable_input,
  input wire logic undervolt_7v,
  input wire logic undervolt_4v5,
  input wire logic temp_above_100,
  input wire logic temp_above_120,
  input wire logic temp_above_136,
  input wire logic temp_above_150,
  input wire logic [1:0] high_side_short_det,
  input wire logic [1:0] low_side_short_det,
  // chopper, same clock
  input wire logic [1:0] chop_event,
  input wire logic [1:0] coil_polarity,
  input wire logic [1:0] coil_current_low,
  // power stage controls
  output logic [1:0] bridge_enable,
  output logic high_side_detect_sensitivity,
  output logic [1:0] gate_current_level,
  output logic resonance_damping_enable,
  output logic logic_reset
);
  import dfp_pkg::*;

  typedef struct packed {
    dfp_fsm_t st;
    logic [DFP_CNT_W-1:0] cnt;
    logic [1:0] tries;
    logic short_flag;
    logic hs_flag;
    logic ls_flag;
    logic open_flag;
    logic last_pol;
    logic chop_seen;
  } dfp_coil_t;

  typedef struct packed {
    logic [DFP_CFG_W-1:0] cfg;
    dfp_coil_t [1:0] coil;
    logic thermal_shutdown_flag;
    logic [1:0] gate_lvl;
    logic ack;
    logic [31:0] dat;
  } dfp_state_t;

  dfp_state_t r;
  dfp_state_t next_r;

  // ==========================================================
  // pin synchronisers
  localparam int SYNC_W = 11;
  localparam logic [SYNC_W-1:0] SYNC_INIT = 11'h006;
  logic [SYNC_W-1:0] pins_s;
  dfp_sync #(.W(SYNC_W), .INIT(SYNC_INIT)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({low_side_short_det, high_side_short_det, temp_above_150, temp_above_136,
        temp_above_120, temp_above_100, undervolt_4v5, undervolt_7v, driver_disable_input}),
    .q(pins_s)
  );

  logic disable_pin_s;
  logic uv7_s;
  logic uv45_s;
  logic t100_s;
  logic t120_s;
  logic t136_s;
  logic t150_s;
  logic [1:0] hs_s;
  logic [1:0] ls_s;
  assign disable_pin_s = pins_s[0];
  assign uv7_s = pins_s[1];
  assign uv45_s = pins_s[2];
  assign t100_s = pins_s[3];
  assign t120_s = pins_s[4];
  assign t136_s = pins_s[5];
  assign t150_s = pins_s[6];
  assign hs_s = pins_s[8:7];
  assign ls_s = pins_s[10:9];

  // ==========================================================
  // config fields
  logic [1:0] delay_sel;
  logic protect_dis;
  logic ls_enable;
  logic thresh_sel;
  logic low_supply;
  logic [1:0] slope;
  logic [3:0] off_time;
  logic [4:0] scale;
  assign delay_sel = r.cfg[DFP_CFG_DELAY +: 2];
  assign protect_dis = r.cfg[DFP_CFG_PROTECT_DIS];
  assign ls_enable = r.cfg[DFP_CFG_LS_ENABLE];
  assign thresh_sel = r.cfg[DFP_CFG_THRESH_SEL];
  assign low_supply = r.cfg[DFP_CFG_LOW_SUPPLY];
  assign slope = r.cfg[DFP_CFG_SLOPE +: 2];
  assign off_time = r.cfg[DFP_CFG_OFF_TIME +: 4];
  assign scale = r.cfg[DFP_CFG_SCALE +: 5];

  logic uv_now;
  logic drv_off;
  logic [DFP_CNT_W-1:0] delay_cyc;
  assign uv_now = low_supply ? uv45_s : uv7_s;
  assign drv_off = disable_pin_s | (off_time == 4'h0) | r.thermal_shutdown_flag;
  assign delay_cyc = dfp_delay_cycles(delay_sel);

  // ==========================================================
  // status word
  logic [31:0] status;
  always_comb begin
    status = 32'h00000000;
    for (int c = 0; c < 2; c++) begin
      status[DFP_ST_SHORT + c] = r.coil[c].short_flag;
      status[DFP_ST_LS_SHORT + c] = r.coil[c].ls_flag;
      status[DFP_ST_HS_SHORT + c] = r.coil[c].hs_flag;
      status[DFP_ST_OPEN_LOAD + c] = r.coil[c].open_flag;
    end
    status[DFP_ST_PREWARN] = t100_s;
    status[DFP_ST_THERMAL] = r.thermal_shutdown_flag;
    status[DFP_ST_SCALE +: 5] = scale;
  end

  // ==========================================================
  // next state
  logic req;
  logic [31:0] lane_mask;
  logic hs_det;
  logic ls_det;
  assign req = wb_cyc_i & wb_stb_i;
  assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_comb begin
    next_r = r;
    hs_det = 1'b0;
    ls_det = 1'b0;

    // bus: ack one cycle after the request, write at the acked edge
    next_r.ack = req & ~r.ack;
    if (req & ~r.ack) begin
      unique case (wb_adr_i)
        DFP_ADDR_CONFIG: next_r.dat = {{(32 - DFP_CFG_W){1'b0}}, r.cfg};
        DFP_ADDR_STATUS: next_r.dat = status;
        default: next_r.dat = 32'h00000000;
      endcase
    end
    if (req & r.ack & wb_we_i & (wb_adr_i == DFP_ADDR_CONFIG)) begin
      next_r.cfg = r.cfg & ~lane_mask[DFP_CFG_W-1:0] | wb_dat_i[DFP_CFG_W-1:0] &
        lane_mask[DFP_CFG_W-1:0];
    end

    // thermal: trip wins over release
    if (thresh_sel ? t136_s : t150_s) begin
      next_r.thermal_shutdown_flag = 1'b1;
    end else if (!t120_s) begin
      next_r.thermal_shutdown_flag = 1'b0;
    end

    // gate drive step
    unique case (slope)
      DFP_SLOPE_MIN: next_r.gate_lvl = 2'h0;
      DFP_SLOPE_MIN_TC: next_r.gate_lvl = t100_s ? 2'h1 : 2'h0;
      DFP_SLOPE_MED_TC: next_r.gate_lvl = t100_s ? 2'h2 : 2'h1;
      DFP_SLOPE_MAX: next_r.gate_lvl = 2'h3;
    endcase

    for (int c = 0; c < 2; c++) begin
      hs_det = hs_s[c] & ~protect_dis;
      ls_det = ls_s[c] & ls_enable;

      // short supervision
      unique case (r.coil[c].st)
        DFP_ARMED: begin
          if (drv_off || !(hs_det || ls_det)) begin
            next_r.coil[c].cnt = '0;
          end else if (r.coil[c].cnt == delay_cyc - 1'b1) begin
            next_r.coil[c].cnt = '0;
            if (r.coil[c].tries == 2'(DFP_RETRIES)) begin
              next_r.coil[c].st = DFP_LOCKED;
              next_r.coil[c].short_flag = 1'b1;
              next_r.coil[c].hs_flag = r.coil[c].hs_flag | hs_det;
              next_r.coil[c].ls_flag = r.coil[c].ls_flag | ls_det;
            end else begin
              next_r.coil[c].tries = r.coil[c].tries + 2'h1;
              next_r.coil[c].st = DFP_PAUSE;
            end
          end else begin
            next_r.coil[c].cnt = r.coil[c].cnt + 1'b1;
          end
        end
        DFP_PAUSE: begin
          next_r.coil[c].cnt = r.coil[c].cnt + 1'b1;
          if (r.coil[c].cnt == DFP_CNT_W'(DFP_PAUSE_CYC - 1)) begin
            next_r.coil[c].cnt = '0;
            next_r.coil[c].st = DFP_ARMED;
          end
        end
        DFP_LOCKED: next_r.coil[c].st = DFP_LOCKED;
        default: next_r.coil[c].st = DFP_ARMED;
      endcase

      // disabling the driver rearms the coil and clears its short flags; the open load flag is kept
      if (drv_off) begin
        next_r.coil[c].st = DFP_ARMED;
        next_r.coil[c].cnt = '0;
        next_r.coil[c].tries = 2'h0;
        next_r.coil[c].short_flag = 1'b0;
        next_r.coil[c].hs_flag = 1'b0;
        next_r.coil[c].ls_flag = 1'b0;
      end

      // open load, judged at each polarity change unless the current is low; flag only, no action
      if (chop_event[c]) begin
        next_r.coil[c].chop_seen = 1'b1;
      end
      if (coil_polarity[c] != r.coil[c].last_pol) begin
        if (!coil_current_low[c]) begin
          next_r.coil[c].open_flag = ~(r.coil[c].chop_seen | chop_event[c]);
        end
        next_r.coil[c].chop_seen = 1'b0;
      end
      next_r.coil[c].last_pol = coil_polarity[c];
    end

    // undervoltage clears everything
    if (rst || uv_now) begin
      next_r = '0;
      next_r.cfg = DFP_CFG_RESET;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  // ==========================================================
  // outputs
  generate
    for (genvar c = 0; c < 2; c++) begin : g_bridge
      // open load plays no part here
      assign bridge_enable[c] = ~drv_off & ~uv_now & (r.coil[c].st == DFP_ARMED);
    end
  endgenerate
  assign high_side_detect_sensitivity = r.cfg[DFP_CFG_SENSITIVITY];
  assign resonance_damping_enable = low_supply;
  assign gate_current_level = r.gate_lvl;
  assign logic_reset = uv_now;
  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.dat;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  uv_clear_a: assert property (uv_now |=> r.cfg == '0 && !r.thermal_shutdown_flag)
    else $error("undervoltage did not clear registers");
  scale_zero_a: assert property (uv_now |=> status[DFP_ST_SCALE +: 5] == 5'h00)
    else $error("scale readback not zero after undervoltage");
  drv_off_a: assert property (drv_off |-> bridge_enable == 2'h0)
    else $error("bridge on while driver disabled");
  thermal_off_a: assert property (r.thermal_shutdown_flag |-> bridge_enable == 2'h0)
    else $error("bridge on during thermal shutdown");
  thermal_hold_a: assert property (r.thermal_shutdown_flag && t120_s && !uv_now
    |=> r.thermal_shutdown_flag)
    else $error("thermal shutdown released above release level");
  thermal_trip_a: assert property ((thresh_sel ? t136_s : t150_s) && !uv_now
    |=> r.thermal_shutdown_flag)
    else $error("thermal shutdown not taken at selected level");
  slope_tc_a: assert property (slope == DFP_SLOPE_MED_TC && t100_s && !uv_now
    |=> gate_current_level == 2'h2)
    else $error("compensated slope not raised");
  bus_ack_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  generate
    for (genvar c = 0; c < 2; c++) begin : g_chk
      lock_retry_a: assert property ($rose(r.coil[c].st == DFP_LOCKED)
        |-> $past(r.coil[c].tries) == 2'h3 && r.coil[c].short_flag)
        else $error("locked without three retries");
      pause_off_a: assert property (r.coil[c].st != DFP_ARMED |-> !bridge_enable[c])
        else $error("bridge on while coil paused or locked");
      lock_detail_a: assert property (r.coil[c].st == DFP_LOCKED
        |-> r.coil[c].hs_flag || r.coil[c].ls_flag)
        else $error("locked coil without detail flag");
      confirm_delay_a: assert property ($rose(r.coil[c].st == DFP_PAUSE)
        |-> $past(r.coil[c].cnt) == $past(delay_cyc) - 1'b1)
        else $error("short confirmed at wrong delay");
      open_set_a: assert property (coil_polarity[c] != r.coil[c].last_pol
        && !coil_current_low[c] && !r.coil[c].chop_seen && !chop_event[c] && !uv_now
        |=> r.coil[c].open_flag)
        else $error("open load not flagged after silent polarity period");
      open_hold_a: assert property (coil_current_low[c] && !uv_now
        |=> $stable(r.coil[c].open_flag))
        else $error("open load updated at low current");
      flag_clear_a: assert property (drv_off && !uv_now |=> !r.coil[c].short_flag)
        else $error("short flag kept while driver disabled");
    end
  endgenerate

endmodule

`default_nettype wire

// [tb/dfp_host.sv]
// wishbone host model that configures the block and reads its flags
`timescale 1ns/100ps
`default_nettype none

module dfp_host (
  // clock
  input wire logic clk,
  // wishbone master side
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat_w,
  input wire logic [31:0] dat_r,
  input wire logic ack
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h0;
  end

  // ==========================================================
  // one classic cycle, held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat_w <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // ==========================================================
  // off time zero, then the new setting
  task automatic restart(input logic [31:0] v);
    logic [31:0] q;
    xfer(1'b1, 8'h00, 32'h0, q);
    xfer(1'b1, 8'h00, v, q);
  endtask
endmodule

`default_nettype wire

// [tb/tb_dfp_top.sv]
// self-checking bench for the driver fault protection block
`timescale 1ns/100ps
`default_nettype none

module tb_dfp_top;
  import dfp_pkg::*;

  // ==========================================================
  // stimulus and observed signals
  localparam logic [31:0] run = 32'h1 << DFP_CFG_OFF_TIME;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic drv_dis = 1'b0;
  logic uv7 = 1'b0;
  logic uv45 = 1'b0;
  logic t100 = 1'b0;
  logic t120 = 1'b0;
  logic t136 = 1'b0;
  logic t150 = 1'b0;
  logic [1:0] hs_det = 2'h0;
  logic [1:0] ls_det = 2'h0;
  logic [1:0] chop = 2'h0;
  logic [1:0] pol = 2'h0;
  logic [1:0] cur_low = 2'h0;
  wire logic cyc;
  wire logic stb;
  wire logic we;
  wire logic [7:0] adr;
  wire logic [3:0] sel;
  wire logic [31:0] dat_w;
  wire logic [31:0] dat_r;
  wire logic ack;
  wire logic [1:0] bridge;
  wire logic sens;
  wire logic [1:0] gate;
  wire logic damp;
  wire logic lrst;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  logic [31:0] rd;

  always #20 clk = ~clk;

  dfp_host u_dfp_host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat_w(dat_w), .dat_r(dat_r), .ack(ack));

  dfp_top u_dfp_top (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .driver_disable_input(drv_dis), .undervolt_7v(uv7), .undervolt_4v5(uv45),
    .temp_above_100(t100), .temp_above_120(t120), .temp_above_136(t136),
    .temp_above_150(t150), .high_side_short_det(hs_det), .low_side_short_det(ls_det),
    .chop_event(chop), .coil_polarity(pol), .coil_current_low(cur_low),
    .bridge_enable(bridge), .high_side_detect_sensitivity(sens),
    .gate_current_level(gate), .resonance_damping_enable(damp), .logic_reset(lrst));

  // ==========================================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_reg(input logic [7:0] a);
    u_dfp_host.xfer(1'b0, a, 32'h0, rd);
  endtask

  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails++;
      end_of_test();
    end
  end

  // ==========================================================
  // scenarios
  task automatic t_reset;
    logic [31:0] q;
    chk("bridge idle", 32'h0, 32'(bridge));
    rd_reg(DFP_ADDR_CONFIG);
    chk("config reset", 32'h0, rd);
    u_dfp_host.xfer(1'b1, DFP_ADDR_STATUS, 32'hffffffff, q);
    rd_reg(DFP_ADDR_STATUS);
    chk("status ro", 32'h0, rd);
    rd_reg(8'h08);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
  endtask

  task automatic t_config;
    logic [31:0] v;
    v = run | (32'h1 << DFP_CFG_SENSITIVITY) | (32'h1 << DFP_CFG_LOW_SUPPLY);
    u_dfp_host.restart(v);
    tick(2);
    chk("sensitivity", 32'h1, 32'(sens));
    chk("damping", 32'h1, 32'(damp));
    rd_reg(DFP_ADDR_CONFIG);
    chk("config back", v, rd);
    u_dfp_host.restart(run);
    tick(2);
    chk("sens low", 32'h0, 32'(sens));
    chk("damp low", 32'h0, 32'(damp));
    chk("bridge on", 32'h3, 32'(bridge));
    drv_dis <= 1'b1;
    tick(6);
    chk("pin off", 32'h0, 32'(bridge));
    drv_dis <= 1'b0;
    tick(6);
    chk("pin on", 32'h3, 32'(bridge));
    $display("test config done");
  endtask

  task automatic t_delay;
    int n;
    int d[4];
    d = '{DFP_DELAY_00_CYC, DFP_DELAY_01_CYC, DFP_DELAY_10_CYC, DFP_DELAY_11_CYC};
    for (int s = 0; s < 4; s++) begin
      u_dfp_host.restart(run | (32'(s) << DFP_CFG_DELAY));
      tick(2);
      hs_det <= 2'b01;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (bridge[0] !== 1'b0 && n < 400);
      hs_det <= 2'b00;
      chk("delay window", 32'h1, 32'(n >= d[s] + 2 && n <= d[s] + 6));
      chk("other coil", 32'h1, 32'(bridge[1]));
    end
    $display("test delay done");
  endtask

  task automatic t_retry;
    int rises;
    logic last;
    rises = 0;
    last = 1'b1;
    u_dfp_host.restart(run | (32'h3 << DFP_CFG_DELAY));
    hs_det <= 2'b01;
    repeat (4 * (DFP_DELAY_11_CYC + DFP_PAUSE_CYC + 10)) begin
      @(posedge clk);
      if (bridge[0] === 1'b1 && last === 1'b0) rises++;
      last = bridge[0];
      if (bridge[1] !== 1'b1) rises = 99;
    end
    chk("retries", 32'(DFP_RETRIES), 32'(rises));
    chk("locked", 32'h2, 32'(bridge));
    rd_reg(DFP_ADDR_STATUS);
    chk("short flags", 32'h11, 32'(rd[5:0]));
    hs_det <= 2'b00;
    u_dfp_host.restart(run);
    rd_reg(DFP_ADDR_STATUS);
    chk("flags cleared", 32'h0, 32'(rd[5:0]));
    chk("restarted", 32'h3, 32'(bridge));
    $display("test retry done");
  endtask

  task automatic t_gates;
    logic [31:0] v;
    v = run | (32'h3 << DFP_CFG_DELAY);
    u_dfp_host.restart(v);
    ls_det <= 2'b10;
    tick(150);
    chk("low side idle", 32'h3, 32'(bridge));
    u_dfp_host.restart(v | (32'h1 << DFP_CFG_LS_ENABLE));
    tick(40);
    chk("low side trip", 32'h1, 32'(bridge));
    tick(1100);
    chk("low side lock", 32'h1, 32'(bridge));
    rd_reg(DFP_ADDR_STATUS);
    chk("low side flags", 32'h0a, 32'(rd[5:0]));
    ls_det <= 2'b00;
    u_dfp_host.restart(v | (32'h1 << DFP_CFG_PROTECT_DIS));
    hs_det <= 2'b11;
    tick(150);
    chk("high side off", 32'h3, 32'(bridge));
    hs_det <= 2'b00;
    $display("test gates done");
  endtask

  task automatic t_thermal;
    logic [1:0] g0;
    for (int m = 0; m < 4; m++) begin
      u_dfp_host.restart(run | (32'(m) << DFP_CFG_SLOPE));
      tick(2);
      g0 = gate;
      t100 <= 1'b1;
      tick(6);
      chk("gate step", 32'(g0) + 32'(m == 1 || m == 2), 32'(gate));
      rd_reg(DFP_ADDR_STATUS);
      chk("prewarn", 32'h1, 32'(rd[DFP_ST_PREWARN]));
      t100 <= 1'b0;
      tick(6);
    end
    u_dfp_host.restart(run | (32'h1 << DFP_CFG_THRESH_SEL));
    t120 <= 1'b1;
    t136 <= 1'b1;
    tick(6);
    chk("trip low", 32'h0, 32'(bridge));
    rd_reg(DFP_ADDR_STATUS);
    chk("shutdown flag", 32'h1, 32'(rd[DFP_ST_THERMAL]));
    t136 <= 1'b0;
    tick(6);
    chk("held off", 32'h0, 32'(bridge));
    t120 <= 1'b0;
    tick(6);
    chk("released", 32'h3, 32'(bridge));
    u_dfp_host.restart(run);
    t120 <= 1'b1;
    t136 <= 1'b1;
    tick(6);
    chk("no trip low", 32'h3, 32'(bridge));
    t150 <= 1'b1;
    tick(6);
    chk("trip high", 32'h0, 32'(bridge));
    t150 <= 1'b0;
    t136 <= 1'b0;
    t120 <= 1'b0;
    tick(6);
    $display("test thermal done");
  endtask

  // slow polarity changes, as in microstepping
  task automatic t_open;
    u_dfp_host.restart(run);
    pol <= 2'b01;
    tick(4);
    pol <= 2'b00;
    tick(2);
    rd_reg(DFP_ADDR_STATUS);
    chk("open set", 32'h1, 32'(rd[DFP_ST_OPEN_LOAD +: 2]));
    chk("no action", 32'h3, 32'(bridge));
    chop <= 2'b01;
    tick(1);
    chop <= 2'b00;
    tick(2);
    pol <= 2'b01;
    tick(2);
    rd_reg(DFP_ADDR_STATUS);
    chk("open clear", 32'h0, 32'(rd[DFP_ST_OPEN_LOAD +: 2]));
    cur_low <= 2'b01;
    tick(2);
    pol <= 2'b00;
    tick(2);
    rd_reg(DFP_ADDR_STATUS);
    chk("open held", 32'h0, 32'(rd[DFP_ST_OPEN_LOAD +: 2]));
    cur_low <= 2'b00;
    $display("test open load done");
  endtask

  task automatic t_uv;
    u_dfp_host.restart(run | (32'h15 << DFP_CFG_SCALE));
    rd_reg(DFP_ADDR_STATUS);
    chk("scale", 32'h15, 32'(rd[DFP_ST_SCALE +: 5]));
    uv7 <= 1'b1;
    tick(6);
    chk("uv reset", 32'h1, 32'(lrst));
    chk("uv bridge", 32'h0, 32'(bridge));
    uv7 <= 1'b0;
    tick(8);
    rd_reg(DFP_ADDR_CONFIG);
    chk("uv config", 32'h0, rd);
    rd_reg(DFP_ADDR_STATUS);
    chk("uv scale", 32'h0, 32'(rd[DFP_ST_SCALE +: 5]));
    u_dfp_host.restart(run | (32'h1 << DFP_CFG_LOW_SUPPLY));
    uv7 <= 1'b1;
    tick(6);
    chk("low supply", 32'h0, 32'(lrst));
    uv45 <= 1'b1;
    tick(6);
    chk("low level", 32'h1, 32'(lrst));
    uv45 <= 1'b0;
    uv7 <= 1'b0;
    tick(8);
    $display("test undervoltage done");
  endtask

  initial begin
    tick(6);
    rst <= 1'b0;
    tick(8);
    t_reset();
    t_config();
    t_delay();
    t_retry();
    t_gates();
    t_thermal();
    t_open();
    t_uv();
    end_of_test();
  end
endmodule

`default_nettype wire
